/* File: logic/tdp_pkg.sv */
// Shared constants, types and functions of the dual-port memory
// What this block does
// - A write strobe at 1 stores the port data; at 0 the addressed word is read.
// - No-read-on-write keeps the port output at its last read value during writes.
// - Each port may have an enable input and an output reset input, chosen at build.
// - Both ports reading one word at once both get the stored value.
// - Both ports writing one word at once make both outputs invalid, except a no-read-on-write port's output, which holds.
// - Write-read on one word keeps the memory intact; writer's mode decides reader's output.
// - Writer in read-before-write lets the other port read the old value.
// - Writer in read-after-write or no-read-on-write makes the other port's output invalid.
// - Each port's write mode is chosen separately at build time.
// - Depth is a port A word count of at least two; port B depth follows from the ratio.
// - Memory starts from an initial vector, extra entries dropped, missing words zero.
// - Initial words are saturated and rounded to port A precision.
// - Distributed variant: port A always read-before-write, port B read only.
// - Each output register starts from its own saturated initial value.
// - Output register reset input exists only with read latency of one.
// - Port enable input exists only with read latency of one or more.
// - Block variant address width is exactly ceil(log2(depth)), drivers match it.
// - Block variant word width is limited by depth, 256 bits down to 3.
// - Distributed variant depth 16 to 65536 (4096 small targets), width 1 to 1024.
// - Fastest clock needs no output resets, depth under 16384, latency two or more.
package tdp_pkg;

  typedef enum logic [1:0] {
    MODE_RBW = 2'b00,
    MODE_RAW = 2'b01,
    MODE_NRW = 2'b10
  } mode_e;

  // ==========================================================
  // Register map
  localparam int REG_AW = 4;
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STAT = 4'h4;
  localparam logic [3:0] OFS_CNT = 4'h8;
  localparam int CTRL_WBLOCK = 0;
  localparam int STAT_FAST = 0;
  localparam int STAT_WW = 1;
  localparam int STAT_WR = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Defaults and limits
  localparam int DEPTH_DEF = 1024;
  localparam int WIDTH_DEF = 8;
  localparam int LAT_DEF = 1;
  localparam int DIST_DEPTH_MIN = 16;
  localparam int DIST_DEPTH_MAX = 65536;
  localparam int DIST_DEPTH_SMALL = 4096;
  localparam int DIST_WIDTH_MAX = 1024;
  localparam int FAST_DEPTH = 16384;
  localparam int FAST_LAT = 2;

  // Widest block word for a depth
  function automatic int max_width(input longint depth);
    if (depth <= 2048) return 256;
    else if (depth <= 4096) return 192;
    else if (depth <= 8192) return 96;
    else if (depth <= 16384) return 48;
    else if (depth <= 32768) return 24;
    else if (depth <= 65536) return 12;
    else if (depth <= 131072) return 6;
    else return 3;
  endfunction

  // Clamp an integer into an unsigned field of w bits
  function automatic longint sat_u(input longint v, input int w);
    if (v < 0) return 0;
    if (w < 63 && v > ((64'sd1 <<< w) - 1)) return (64'sd1 <<< w) - 1;
    return v;
  endfunction

endpackage

/* File: logic/tdp_out_reg.sv */
// Output register and read pipeline of one memory port
`timescale 1ns/10ps
module tdp_out_reg #(
  parameter int W = 8,
  parameter int LAT = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic rst_out,
  input wire logic en,
  input wire logic upd,
  // Data
  input wire logic [W-1:0] nv,
  output logic [W-1:0] dout
);
  logic [W-1:0] pipe_q [LAT];

  // Reset and output reset load the initial value
  always_ff @(posedge aclk) begin
    if (!aresetn || rst_out) begin
      pipe_q[0] <= INIT;
    // Held while the port is disabled
    end else if (en && upd) begin
      pipe_q[0] <= nv;
    end
  end

  for (genvar i = 1; i < LAT; i++) begin : g_pipe
    always_ff @(posedge aclk) begin
      if (!aresetn || rst_out) begin
        pipe_q[i] <= INIT;
      end else if (en) begin
        pipe_q[i] <= pipe_q[i-1];
      end
    end
  end

  assign dout = pipe_q[LAT-1];
endmodule // tdp_out_reg

/* File: logic/tdp_axil_regs.sv */
// AXI4-Lite slave front end for the control registers
`timescale 1ns/10ps
module tdp_axil_regs (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address and data
  input wire logic [tdp_pkg::REG_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read
  input wire logic [tdp_pkg::REG_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Register side
  output logic reg_wr,
  output logic [tdp_pkg::REG_AW-1:0] reg_waddr,
  output logic [31:0] reg_wdata,
  output logic [3:0] reg_wstrb,
  input wire logic reg_werr,
  output logic [tdp_pkg::REG_AW-1:0] reg_raddr,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rerr
);
  import tdp_pkg::*;

  logic aw_full_q, w_full_q, bvalid_q, rvalid_q;
  logic [REG_AW-1:0] addr_q;
  logic [31:0] data_q, rdata_q;
  logic [3:0] strb_q;
  logic [1:0] bresp_q, rresp_q;

  assign s_axi_awready = !aw_full_q && !bvalid_q;
  assign s_axi_wready = !w_full_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign reg_wr = aw_full_q && w_full_q && !bvalid_q;
  assign reg_waddr = addr_q;
  assign reg_wdata = data_q;
  assign reg_wstrb = strb_q;
  assign reg_raddr = s_axi_araddr;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // Address and data are caught in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      addr_q <= '0;
      data_q <= 32'h0;
      strb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        addr_q <= s_axi_awaddr;
      end else if (reg_wr) begin
        aw_full_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        data_q <= s_axi_wdata;
        strb_q <= s_axi_wstrb;
      end else if (reg_wr) begin
        w_full_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= RESP_OKAY;
    end else begin
      if (reg_wr) begin
        bvalid_q <= 1'b1;
        bresp_q <= reg_werr ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_q <= 1'b1;
        rdata_q <= reg_rdata;
        rresp_q <= reg_rerr ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end
endmodule // tdp_axil_regs

/* File: logic/true_dual_port_ram.sv */
// True dual-port memory with collision handling and control registers
//
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/10ps
module true_dual_port_ram #(
  parameter int DEPTH_A = tdp_pkg::DEPTH_DEF,
  parameter int WIDTH_A = tdp_pkg::WIDTH_DEF,
  parameter int WIDTH_RATIO = 1,
  parameter int LATENCY = tdp_pkg::LAT_DEF,
  parameter tdp_pkg::mode_e MODE_A = tdp_pkg::MODE_RBW,
  parameter tdp_pkg::mode_e MODE_B = tdp_pkg::MODE_RBW,
  parameter bit HAS_EN_A = 1'b0,
  parameter bit HAS_EN_B = 1'b0,
  parameter bit HAS_RST_A = 1'b0,
  parameter bit HAS_RST_B = 1'b0,
  parameter bit DISTRIBUTED = 1'b0,
  parameter bit SMALL_TARGET = 1'b0,
  parameter int INIT_LEN = 1,
  parameter longint INIT_VEC [INIT_LEN] = '{default: 64'sd0},
  parameter longint OUT_INIT_A = 0,
  parameter longint OUT_INIT_B = 0,
  localparam int RB = $clog2(WIDTH_RATIO),
  localparam int AW_A = $clog2(DEPTH_A),
  localparam int AW_B = AW_A - RB,
  localparam int WIDTH_B = WIDTH_A * WIDTH_RATIO
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Port A
  input wire logic en_a,
  input wire logic rst_a,
  input wire logic we_a,
  input wire logic [AW_A-1:0] addr_a,
  input wire logic [WIDTH_A-1:0] din_a,
  output logic [WIDTH_A-1:0] dout_a,
  // Port B
  input wire logic en_b,
  input wire logic rst_b,
  input wire logic we_b,
  input wire logic [AW_B-1:0] addr_b,
  input wire logic [WIDTH_B-1:0] din_b,
  output logic [WIDTH_B-1:0] dout_b,
  // AXI4-Lite write
  input wire logic [tdp_pkg::REG_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [tdp_pkg::REG_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import tdp_pkg::*;

  localparam int WA = WIDTH_A;
  localparam int WB = WIDTH_B;
  localparam int DEPTH_B = DEPTH_A / WIDTH_RATIO;
  localparam bit LAT_ONE = (LATENCY == 1);
  localparam int DIST_MAX = SMALL_TARGET ? DIST_DEPTH_SMALL : DIST_DEPTH_MAX;

  // ==========================================================
  // Build-time checks
  // Ratio is a power of two up to 32
  localparam bit RATIO_OK = (WIDTH_RATIO inside {1, 2, 4, 8, 16, 32})
    && (DEPTH_A % WIDTH_RATIO == 0);
  // Block word width bounded by depth
  localparam bit BLOCK_OK = (WA <= max_width(DEPTH_A)) && (WB <= max_width(DEPTH_B));
  localparam bit DIST_OK = (DEPTH_A >= DIST_DEPTH_MIN) && (DEPTH_A <= DIST_MAX)
    && (WB <= DIST_WIDTH_MAX) && (WA >= 1);
  // Depth is a word count of at least two
  localparam bit CFG_OK = RATIO_OK && (DEPTH_A >= 2) && (LATENCY >= 1)
    && (DISTRIBUTED ? DIST_OK : BLOCK_OK);
  // Flags a configuration that meets the fastest clock
  localparam bit FAST_CFG = !HAS_RST_A && !HAS_RST_B && (DEPTH_A < FAST_DEPTH)
    && (LATENCY >= FAST_LAT);

  // Modes per port, forces port A in the distributed variant
  localparam mode_e MA = DISTRIBUTED ? MODE_RBW : MODE_A;
  localparam mode_e MB = MODE_B;

  // ==========================================================
  // Storage
  logic [WA-1:0] mem [DEPTH_A];

  // Initial vector loaded, short vector padded with zero
  initial begin
    for (int i = 0; i < DEPTH_A; i++) begin
      // Saturated to the port A word
      mem[i] = (i < INIT_LEN) ? WA'(sat_u(INIT_VEC[i], WA)) : '0;
    end
  end

  // ==========================================================
  // Control register wiring
  logic reg_wr, reg_werr, reg_rerr;
  logic [REG_AW-1:0] reg_waddr, reg_raddr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [3:0] reg_wstrb;
  logic wblock_q, wblock_d;
  logic ww_q, ww_d, wr_q, wr_d;
  logic [31:0] cnt_q, cnt_d;

  // ==========================================================
  // Port qualification
  // Optional enable and reset
  // Enable honoured only with a registered read
  wire en_a_eff = (HAS_EN_A && LATENCY >= 1) ? en_a : 1'b1;
  wire en_b_eff = (HAS_EN_B && LATENCY >= 1) ? en_b : 1'b1;
  // Output reset offered only with latency one
  wire rst_a_eff = HAS_RST_A && LAT_ONE && rst_a;
  wire rst_b_eff = HAS_RST_B && LAT_ONE && rst_b;
  wire we_a_eff = we_a && en_a_eff && !wblock_q;
  // Port B never writes in the distributed variant
  wire we_b_eff = we_b && en_b_eff && !wblock_q && !DISTRIBUTED;
  wire rd_a_act = en_a_eff && !we_a_eff;
  wire rd_b_act = en_b_eff && !we_b_eff;

  // Port B word covers ratio consecutive port A words
  wire [AW_A-1:0] base_b = AW_A'(addr_b) << RB;
  wire overlap = (addr_a >> RB) == AW_A'(addr_b);
  wire ww_hit = we_a_eff && we_b_eff && overlap;
  wire wr_hit = overlap && ((we_a_eff && rd_b_act) || (we_b_eff && rd_a_act));

  // ==========================================================
  // Read of stored words
  logic [WA-1:0] rd_a_old;
  logic [WB-1:0] rd_b_old;
  assign rd_a_old = mem[addr_a];
  for (genvar k = 0; k < WIDTH_RATIO; k++) begin : g_lane
    assign rd_b_old[k*WA +: WA] = mem[base_b + AW_A'(k)];
  end

  // Write strobe stores the port data
  always_ff @(posedge aclk) begin
    for (int k = 0; k < WIDTH_RATIO; k++) begin
      if (we_b_eff) begin
        mem[base_b + AW_A'(k)] <= din_b[k*WA +: WA];
      end
    end
    if (we_a_eff) begin
      mem[addr_a] <= din_a;
    end
  end

  // ==========================================================
  // Next output values
  logic [WA-1:0] nv_a;
  logic [WB-1:0] nv_b;
  logic upd_a, upd_b;

  always_comb begin
    nv_a = rd_a_old;
    upd_a = 1'b1;
    if (we_a_eff) begin
      case (MA)
        MODE_RBW: nv_a = rd_a_old;
        MODE_RAW: nv_a = din_a;
        default: upd_a = 1'b0;
      endcase
    end
    // Write-write on one word spoils both outputs, except a no-read-on-write port's, which holds
    if (ww_hit) begin
      nv_a = 'x;
    // Writer not in read-before-write spoils the reader
    end else if (rd_a_act && we_b_eff && overlap && MB != MODE_RBW) begin
      nv_a = 'x;
    end
  end

  always_comb begin
    nv_b = rd_b_old;
    upd_b = 1'b1;
    if (we_b_eff) begin
      case (MB)
        MODE_RBW: nv_b = rd_b_old;
        MODE_RAW: nv_b = din_b;
        default: upd_b = 1'b0;
      endcase
    end
    if (ww_hit) begin
      nv_b = 'x;
    // Read-before-write writer leaves old data readable
    end else if (rd_b_act && we_a_eff && overlap && MA != MODE_RBW) begin
      nv_b = 'x;
    end
  end

  // ==========================================================
  // Output registers
  // Saturated initial values per port
  tdp_out_reg #(.W(WA), .LAT(LATENCY), .INIT(WA'(sat_u(OUT_INIT_A, WA)))) u_out_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .rst_out(rst_a_eff),
    .en(en_a_eff),
    .upd(upd_a),
    .nv(nv_a),
    .dout(dout_a)
  );

  tdp_out_reg #(.W(WB), .LAT(LATENCY), .INIT(WB'(sat_u(OUT_INIT_B, WB)))) u_out_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .rst_out(rst_b_eff),
    .en(en_b_eff),
    .upd(upd_b),
    .nv(nv_b),
    .dout(dout_b)
  );

  // ==========================================================
  // Register bus
  tdp_axil_regs u_regs (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .reg_wr(reg_wr),
    .reg_waddr(reg_waddr),
    .reg_wdata(reg_wdata),
    .reg_wstrb(reg_wstrb),
    .reg_werr(reg_werr),
    .reg_raddr(reg_raddr),
    .reg_rdata(reg_rdata),
    .reg_rerr(reg_rerr)
  );

  wire w_ctrl = reg_waddr == OFS_CTRL;
  wire w_stat = reg_waddr == OFS_STAT;
  wire w_cnt = reg_waddr == OFS_CNT;
  assign reg_werr = !(w_ctrl || w_stat || w_cnt);
  wire clr_ww = reg_wr && w_stat && reg_wstrb[0] && reg_wdata[STAT_WW];
  wire clr_wr = reg_wr && w_stat && reg_wstrb[0] && reg_wdata[STAT_WR];

  // Hardware set wins over a clear in the same cycle
  assign wblock_d = (reg_wr && w_ctrl && reg_wstrb[0]) ? reg_wdata[CTRL_WBLOCK] : wblock_q;
  assign ww_d = ww_hit || (ww_q && !clr_ww);
  // Write-read hits are recorded, memory untouched
  assign wr_d = wr_hit || (wr_q && !clr_wr);
  assign cnt_d = (ww_hit || wr_hit) ? cnt_q + 32'h1 : cnt_q;

  wire r_ctrl = reg_raddr == OFS_CTRL;
  wire r_stat = reg_raddr == OFS_STAT;
  wire r_cnt = reg_raddr == OFS_CNT;
  assign reg_rerr = !(r_ctrl || r_stat || r_cnt);
  wire [31:0] stat_word = {29'h0, wr_q, ww_q, FAST_CFG};
  assign reg_rdata = r_ctrl ? {31'h0, wblock_q} :
                     r_stat ? stat_word :
                     r_cnt ? cnt_q : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wblock_q <= 1'b0;
      ww_q <= 1'b0;
      wr_q <= 1'b0;
      cnt_q <= 32'h0;
    end else begin
      wblock_q <= wblock_d;
      ww_q <= ww_d;
      wr_q <= wr_d;
      cnt_q <= cnt_d;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_cfg_limits: assert property (CFG_OK)
    else $error("memory configuration outside supported limits");

  a_write_store: assert property (
    we_a_eff && !ww_hit |=> mem[$past(addr_a)] == $past(din_a))
    else $error("port A write not stored");

  a_own_raw: assert property (
    LAT_ONE && we_a_eff && MA == MODE_RAW && !ww_hit && !rst_a_eff
    |=> dout_a == $past(din_a))
    else $error("read-after-write output not new data");

  a_own_raw_b: assert property (
    LAT_ONE && we_b_eff && MB == MODE_RAW && !ww_hit && !rst_b_eff
    |=> dout_b == $past(din_b))
    else $error("port B read-after-write output not new data");

  a_nrw_hold: assert property (
    LAT_ONE && we_b_eff && MB == MODE_NRW && !rst_b_eff |=> $stable(dout_b))
    else $error("no-read-on-write output moved");

  a_en_hold: assert property (
    LAT_ONE && !en_a_eff && !rst_a_eff |=> $stable(dout_a))
    else $error("disabled port output changed");

  a_rr_both: assert property (
    LAT_ONE && rd_a_act && rd_b_act && overlap && !rst_a_eff && !rst_b_eff
    |=> dout_a == $past(rd_a_old) && dout_b == $past(rd_b_old))
    else $error("read-read collision lost data");

  a_rbw_other: assert property (
    LAT_ONE && MA == MODE_RBW && we_a_eff && rd_b_act && overlap && !rst_b_eff
    |=> dout_b == $past(rd_b_old))
    else $error("reader did not see old word");

  a_rst_out: assert property (
    rst_a_eff |=> dout_a == WA'(sat_u(OUT_INIT_A, WA)))
    else $error("output reset value wrong");

  a_ww_flag: assert property (
    ww_hit |=> ww_q ##1 (ww_q || $past(clr_ww)))
    else $error("write-write collision not recorded");

  a_wblock: assert property (
    wblock_q && we_a |=> mem[$past(addr_a)] == $past(rd_a_old))
    else $error("blocked write changed memory");

  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");

  c_ww: cover property (ww_hit);
  c_wr: cover property (wr_hit ##1 reg_wr && clr_wr);
  c_rr: cover property (rd_a_act && rd_b_act && overlap);
  c_reg: cover property (reg_wr && w_ctrl ##[1:4] we_a && wblock_q);
endmodule // true_dual_port_ram

/* File: verif/port_user.sv */
// Behavioural user logic that drives one memory port
`timescale 1ns/10ps
module port_user #(
  parameter int AW = 4,
  parameter int W = 8
) (
  // Port pins
  output logic en,
  output logic we,
  output logic [AW-1:0] addr,
  output logic [W-1:0] din
);
  initial begin
    en = 1'b0;
    we = 1'b0;
    addr = '0;
    din = '0;
  end
  // Called at a rising edge; new pin values land just after it
  task automatic drive(input logic e, input logic w, input logic [AW-1:0] a,
                       input logic [W-1:0] d);
    en <= e;
    we <= w;
    addr <= a;
    // Released data bus shows the inverse of its last value
    din <= w ? d : ~din;
  endtask
endmodule // port_user

/* File: verif/true_dual_port_ram_bench.sv */
// Self-checking bench of the dual-port memory with a reference model
`timescale 1ns/10ps
module true_dual_port_ram_bench;
  import tdp_pkg::*;
  // ==========================================================
  // Signals and reference state
  localparam int DEPTH = 16;
  localparam int RATIO = 2;
  localparam int WORD_A = 8;
  localparam int WORD_B = WORD_A * RATIO;
  localparam int ADDR_A = $clog2(DEPTH);
  localparam int ADDR_B = ADDR_A - $clog2(RATIO);
  localparam int INIT_N = 2;
  localparam bit USED = 1'b1;
  localparam longint OUT_A = 7;
  localparam longint INIT_V [INIT_N] = '{64'sd3, 64'sd300};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic rst_a = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] s_axi_wstrb = 4'h0;
  int bad_count = 0;
  int samples_checked = 0;
  int mem [16];
  int a;
  int d;
  logic [31:0] rd;
  logic [1:0] rs;
  logic en_a, we_a, en_b, we_b;
  logic [3:0] addr_a;
  logic [7:0] din_a, dout_a;
  logic [2:0] addr_b;
  logic [15:0] din_b, dout_b;
  logic [3:0] s_axi_awaddr = '0;
  logic [3:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  always #4 aclk = ~aclk;
  // ==========================================================
  // Design and port users
  // different write modes on the two ports
  true_dual_port_ram #(.DEPTH_A(DEPTH), .WIDTH_A(WORD_A), .WIDTH_RATIO(RATIO),
    .LATENCY(LAT_DEF), .MODE_A(MODE_RBW), .MODE_B(MODE_RAW), .HAS_EN_A(USED),
    .HAS_EN_B(USED), .HAS_RST_A(USED), .INIT_LEN(INIT_N), .INIT_VEC(INIT_V),
    .OUT_INIT_A(OUT_A)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .en_a(en_a), .rst_a(rst_a), .we_a(we_a),
    .addr_a(addr_a), .din_a(din_a), .dout_a(dout_a), .en_b(en_b), .rst_b(rst_b),
    .we_b(we_b), .addr_b(addr_b), .din_b(din_b), .dout_b(dout_b),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  port_user #(.AW(ADDR_A), .W(WORD_A)) i_user_a (.en(en_a), .we(we_a), .addr(addr_a),
    .din(din_a));
  port_user #(.AW(ADDR_B), .W(WORD_B)) i_user_b (.en(en_b), .we(we_b), .addr(addr_b),
    .din(din_b));
  // ==========================================================
  // Tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (bad_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One access on each port; outputs are looked at after the taking edge
  task automatic step(input logic ea, input logic wa, input logic [3:0] aa,
    input logic [7:0] da, input logic eb, input logic wb, input logic [2:0] ab,
    input logic [15:0] db);
    @(posedge aclk);
    i_user_a.drive(ea, wa, aa, da);
    i_user_b.drive(eb, wb, ab, db);
    @(posedge aclk);
    #1;
  endtask
  task automatic axi(input logic wr, input logic [3:0] ad, input logic [31:0] dt,
                     output logic [1:0] rsp, output logic [31:0] dat);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_araddr <= ad;
    s_axi_wdata <= dt;
    s_axi_wstrb <= {3'($urandom), 1'b1};
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_bready && s_axi_bvalid === 1'b1) break;
      if (s_axi_rready && s_axi_rvalid === 1'b1) break;
    end
    if (n < 50) begin
      rsp = wr ? s_axi_bresp : s_axi_rresp;
      dat = s_axi_rdata;
      s_axi_bready <= 1'b0;
      s_axi_rready <= 1'b0;
    end else begin
      bad_count++;
      finish_test();
    end
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    finish_test();
  end
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 0;
    for (int i = 0; i < 2; i++) mem[i] = INIT_V[i] > 255 ? 255 : int'(INIT_V[i]);
    void'($urandom(64870));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    chk("dout_a start", dout_a, 32'h7);
    chk("dout_b start", dout_b, 32'h0);
    for (int i = 0; i < 16; i++) begin
      step(1'b1, 1'b0, i[3:0], 8'h0, 1'b0, 1'b0, 3'h0, 16'h0);
      chk("start word", dout_a, mem[i]);
    end
    repeat (8) begin
      a = $urandom % 16;
      d = $urandom % 256;
      step(1'b1, 1'b1, a[3:0], d[7:0], 1'b0, 1'b0, 3'h0, 16'h0);
      chk("a old on write", dout_a, mem[a]);
      mem[a] = d;
    end
    for (int j = 0; j < 8; j++) begin
      step(1'b0, 1'b0, 4'h0, 8'h0, 1'b1, 1'b0, j[2:0], 16'h0);
      chk("b wide read", dout_b, mem[2*j+1] * 256 + mem[2*j]);
    end
    d = $urandom % 65536;
    step(1'b0, 1'b0, 4'h0, 8'h0, 1'b1, 1'b1, 3'h3, d[15:0]);
    chk("b new on write", dout_b, d);
    mem[6] = d % 256;
    mem[7] = d / 256;
    step(1'b1, 1'b0, 4'h0, 8'h0, 1'b0, 1'b0, 3'h0, 16'h0);
    d = mem[0] ^ 255;
    step(1'b0, 1'b1, 4'h0, d[7:0], 1'b0, 1'b0, 3'h0, 16'h0);
    chk("a held", dout_a, mem[0]);
    step(1'b1, 1'b0, 4'h0, 8'h0, 1'b0, 1'b0, 3'h0, 16'h0);
    chk("a no write", dout_a, mem[0]);
    rst_a <= 1'b1;
    rst_b <= 1'b1;
    step(1'b1, 1'b0, 4'h1, 8'h0, 1'b1, 1'b0, 3'h0, 16'h0);
    chk("a out reset", dout_a, 32'h7);
    chk("b no reset port", dout_b, mem[1] * 256 + mem[0]);
    @(posedge aclk);
    rst_a <= 1'b0;
    rst_b <= 1'b0;
    d = $urandom % 256;
    step(1'b1, 1'b1, 4'h4, d[7:0], 1'b1, 1'b0, 3'h2, 16'h0);
    chk("a own old", dout_a, mem[4]);
    chk("b old word", dout_b, mem[5] * 256 + mem[4]);
    mem[4] = d;
    step(1'b1, 1'b0, 4'h4, 8'h0, 1'b1, 1'b0, 3'h2, 16'h0);
    chk("rr a", dout_a, mem[4]);
    chk("rr b", dout_b, mem[5] * 256 + mem[4]);
    step(1'b1, 1'b1, 4'h8, 8'h3c, 1'b1, 1'b1, 3'h4, 16'h1234);
    chk("ww a", dout_a, 32'h000000xx);
    chk("ww b", dout_b, 32'h0000xxxx);
    step(1'b1, 1'b0, 4'ha, 8'h0, 1'b1, 1'b1, 3'h5, 16'h5678);
    chk("raw reader", dout_a, 32'h000000xx);
    chk("raw writer", dout_b, 32'h5678);
    step(1'b0, 1'b0, 4'h0, 8'h0, 1'b0, 1'b0, 3'h0, 16'h0);
    step(1'b1, 1'b0, 4'h8, 8'h0, 1'b0, 1'b0, 3'h0, 16'h0);
    chk("ww word", dout_a, 32'h3c);
    axi(1'b0, OFS_STAT, 32'h0, rs, rd);
    chk("stat resp", rs, RESP_OKAY);
    chk("stat flags", rd, 32'h6);
    axi(1'b0, OFS_CNT, 32'h0, rs, rd);
    chk("collision count", rd, 32'h6);
    axi(1'b1, OFS_STAT, 32'h6, rs, rd);
    axi(1'b0, OFS_STAT, 32'h0, rs, rd);
    chk("stat clear", rd, 32'h0);
    axi(1'b1, OFS_CTRL, 32'h1, rs, rd);
    d = mem[2] ^ 255;
    step(1'b1, 1'b1, 4'h2, d[7:0], 1'b0, 1'b0, 3'h0, 16'h0);
    step(1'b1, 1'b0, 4'h2, 8'h0, 1'b0, 1'b0, 3'h0, 16'h0);
    chk("blocked write", dout_a, mem[2]);
    axi(1'b1, OFS_CTRL, 32'h0, rs, rd);
    axi(1'b0, 4'hc, 32'h0, rs, rd);
    chk("unmapped resp", rs, RESP_SLVERR);
    chk("unmapped data", rd, 32'h0);
    finish_test();
  end
endmodule // true_dual_port_ram_bench
